/* File: hdl/work_bit_delay.sv */
// turn-on / turn-off delay timer for one work bit
`timescale 1ns/1ps
`default_nettype none

module work_bit_delay
	import work_bit_pkg::*;
#(
	parameter int DLY_W = DLY_WIDTH
)
(
	input  wire logic             i_core_clk,
	input  wire logic             i_rst_b,
	input  wire logic             i_eval,
	input  wire logic             i_unit_tick,
	input  wire logic             i_raw,
	input  wire logic [DLY_W-1:0] i_on_dly,
	input  wire logic [DLY_W-1:0] i_off_dly,
	output logic                  o_out
);

	logic [DLY_W-1:0] cnt_q;
	logic [DLY_W-1:0] cnt_d;
	logic             out_q;
	logic             out_d;
	wire              pending;
	wire  [DLY_W-1:0] target;
	wire              expire;

	// input differs from output: a change is waiting for its delay
	assign pending = i_raw != out_q;
	assign target  = i_raw ? i_on_dly : i_off_dly;
	// zero disables the delay; the first unit may be partial (up to -1 unit)
	assign expire  = (target == '0) ||
		(i_unit_tick && (cnt_q >= target - 1'b1));
	// an input that falls back before expiry restarts the count
	assign cnt_d   = !pending ? '0 :
		(i_eval && i_unit_tick) ? cnt_q + 1'b1 : cnt_q;
	assign out_d   = (i_eval && pending && expire) ? i_raw : out_q;

	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			cnt_q <= '0;
			out_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			out_q <= out_d;
		end
	end

	assign o_out = out_q;

endmodule

`default_nettype wire

/* File: hdl/work_bit_logic_combiner.sv */
// package and top module of the work bit logic combiner
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

package work_bit_pkg;
	localparam int NUM_BITS   = 8;
	localparam int SEL_W      = 6;
	localparam int DLY_WIDTH  = 14;
	localparam int ADDR_W     = 6;
	localparam logic [DLY_WIDTH-1:0] DLY_MAX = 14'h270F;
	localparam int CLK_PERIOD_NS  = 40;
	localparam int EVAL_PERIOD_NS = 100000000;
	localparam int EVAL_CYCLES    = EVAL_PERIOD_NS / CLK_PERIOD_NS;
	localparam int EVALS_PER_SEC  = 1000000000 / EVAL_PERIOD_NS;
	localparam int SECS_PER_MIN   = 60;
	// register word addresses
	localparam logic [ADDR_W-1:0] ADR_CTRL   = 6'h00;
	localparam logic [ADDR_W-1:0] ADR_STATUS = 6'h01;
	localparam logic [ADDR_W-1:0] ADR_CFG0   = 6'h08;
	localparam logic [ADDR_W-1:0] ADR_DLY0   = 6'h10;
	// configuration word fields
	localparam int CFG_SEL_A   = 0;
	localparam int CFG_SEL_B   = 6;
	localparam int CFG_SEL_C   = 12;
	localparam int CFG_SEL_D   = 18;
	localparam int CFG_INV_LSB = 24;
	localparam int CFG_OP_LSB  = 28;
	localparam int CFG_OUT_INV = 31;
	localparam int DLY_ON_LSB  = 0;
	localparam int DLY_OFF_LSB = 16;
	localparam int CTRL_MINUTES = 0;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam logic [DLY_WIDTH-1:0] DLY_RESET = 14'h0000;
	// operation form codes
	localparam logic [2:0] OP_NONE = 3'h0;
	localparam logic [2:0] OP_AB_OR_CD = 3'h1;
	localparam logic [2:0] OP_AC_AND_BD = 3'h2;
	localparam logic [2:0] OP_ANY = 3'h3;
	localparam logic [2:0] OP_ALL = 3'h4;
	// source code positions
	localparam int SRC_EVENT1 = 3;
	localparam int SRC_WORK1  = 28;
	localparam int SRC_COUNT  = 36;
endpackage

module work_bit_logic_combiner
	import work_bit_pkg::*;
#(
	parameter int EVAL_CLKS = EVAL_CYCLES
)
(
	input  wire logic              i_core_clk,
	input  wire logic              i_rst_b,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [31:0]       i_wr_data,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	input  wire logic [3:0]        i_event_pin,
	input  wire logic [3:0]        i_event_present,
	input  wire logic [2:0]        i_alarm,
	input  wire logic [1:0]        i_switch_count_alarm,
	input  wire logic              i_ctrl_out1,
	input  wire logic              i_ctrl_out1_linear,
	input  wire logic              i_ctrl_out2,
	input  wire logic              i_ctrl_out2_present,
	input  wire logic              i_ctrl_out2_linear,
	input  wire logic              i_input_error,
	input  wire logic              i_remote_setpoint_error,
	input  wire logic              i_heater_burnout,
	input  wire logic              i_heater_short,
	input  wire logic              i_heater_overcurrent,
	input  wire logic              i_auto_manual,
	input  wire logic              i_run_stop,
	input  wire logic              i_remote_local_setpoint,
	input  wire logic              i_program_start,
	input  wire logic              i_autotune_exec,
	input  wire logic              i_setpoint_ramp,
	input  wire logic [2:0]        i_bank_no,
	input  wire logic              i_program_end,
	output logic [NUM_BITS-1:0]    o_work_bit,
	output logic [31:0]            o_rd_data
);

	function automatic logic pick(input logic [SRC_COUNT-1:0] src,
		input logic [SEL_W-1:0] code);
		// codes beyond the table read as false
		pick = (code < SEL_W'(SRC_COUNT)) ? src[code] : 1'b0;
	endfunction

	function automatic logic combine(input logic [2:0] op, input logic a,
		input logic b, input logic c, input logic d);
		case (op)
			OP_AB_OR_CD:  combine = (a & b) | (c & d);
			OP_AC_AND_BD: combine = (a | c) & (b | d);
			OP_ANY:       combine = a | b | c | d;
			OP_ALL:       combine = a & b & c & d;
			default:      combine = 1'b0;
		endcase
	endfunction

	function automatic logic [DLY_WIDTH-1:0] clamp(input logic [15:0] v);
		clamp = (v > 16'(DLY_MAX)) ? DLY_MAX : v[DLY_WIDTH-1:0];
	endfunction

	logic [31:0]           cfg_q [NUM_BITS];
	logic [DLY_WIDTH-1:0]  on_q  [NUM_BITS];
	logic [DLY_WIDTH-1:0]  off_q [NUM_BITS];
	logic                  minutes_q;
	logic [3:0]            ev_meta_q;
	logic [3:0]            ev_sync_q;
	logic                  pwr_q;
	logic [31:0]           eval_cnt_q;
	logic [7:0]            sec_cnt_q;
	logic [7:0]            min_cnt_q;
	logic                  eval_q;
	logic [31:0]           rd_q;
	wire  [NUM_BITS-1:0]   work;
	wire  [NUM_BITS-1:0]   raw;
	wire  [SRC_COUNT-1:0]  src;
	wire                   sec_wrap;
	wire                   min_wrap;
	wire                   unit_tick;
	wire                   cfg_hit;
	wire                   dly_hit;
	wire  [2:0]            idx;
	wire  [31:0]           rd_mux;

	// event pins come from outside: two flops before use
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			ev_meta_q <= '0;
			ev_sync_q <= '0;
		end
		else
		begin
			ev_meta_q <= i_event_pin;
			ev_sync_q <= ev_meta_q;
		end
	end

	// evaluation cycle strobe and delay unit prescalers
	assign sec_wrap  = sec_cnt_q == 8'(EVALS_PER_SEC - 1);
	assign min_wrap  = min_cnt_q == 8'(SECS_PER_MIN - 1);
	assign unit_tick = sec_wrap && (!minutes_q || min_wrap);

	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			eval_cnt_q <= '0;
			eval_q     <= 1'b0;
			sec_cnt_q  <= '0;
			min_cnt_q  <= '0;
		end
		else
		begin
			eval_q     <= eval_cnt_q == 32'(EVAL_CLKS - 1);
			eval_cnt_q <= (eval_cnt_q == 32'(EVAL_CLKS - 1)) ? '0
				: eval_cnt_q + 32'h1;
			if (eval_q)
			begin
				sec_cnt_q <= sec_wrap ? 8'h00 : sec_cnt_q + 8'h01;
				if (sec_wrap)
					min_cnt_q <= min_wrap ? 8'h00 : min_cnt_q + 8'h01;
			end
		end
	end

	// power-on flag lasts until the end of the first evaluation
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			pwr_q <= 1'b1;
		else if (eval_q)
			pwr_q <= 1'b0;
	end

	assign src[0] = 1'b0;
	assign src[1] = 1'b1;
	assign src[2] = pwr_q;
	assign src[SRC_EVENT1+3:SRC_EVENT1] = ev_sync_q & i_event_present;
	assign src[9:7]  = i_alarm;
	assign src[10] = |i_switch_count_alarm;
	assign src[11] = i_ctrl_out1 & ~i_ctrl_out1_linear;
	// absent or linear output 2 never reads as on
	assign src[12] = i_ctrl_out2 & i_ctrl_out2_present
		& ~i_ctrl_out2_linear;
	assign src[13] = i_input_error;
	assign src[14] = i_remote_setpoint_error;
	assign src[15] = i_heater_burnout;
	assign src[16] = i_heater_short;
	assign src[17] = i_heater_overcurrent;
	assign src[18] = i_auto_manual;
	assign src[19] = i_run_stop;
	assign src[20] = i_remote_local_setpoint;
	assign src[21] = i_program_start;
	assign src[22] = i_autotune_exec;
	assign src[23] = i_setpoint_ramp;
	assign src[26:24] = i_bank_no;
	assign src[27] = i_program_end;
	// registered outputs: a bit sees its peers from the previous cycle
	assign src[SRC_WORK1+NUM_BITS-1:SRC_WORK1] = work;

	genvar g;
	generate
		for (g = 0; g < NUM_BITS; g++)
		begin : g_bit
			wire [3:0] in_v;
			wire [2:0] op;
			wire       comb;
			assign in_v[0] = pick(src, cfg_q[g][CFG_SEL_A +: SEL_W]);
			assign in_v[1] = pick(src, cfg_q[g][CFG_SEL_B +: SEL_W]);
			assign in_v[2] = pick(src, cfg_q[g][CFG_SEL_C +: SEL_W]);
			assign in_v[3] = pick(src, cfg_q[g][CFG_SEL_D +: SEL_W]);
			assign op      = cfg_q[g][CFG_OP_LSB +: 3];
			assign comb    = combine(op,
				in_v[0] ^ cfg_q[g][CFG_INV_LSB],
				in_v[1] ^ cfg_q[g][CFG_INV_LSB+1],
				in_v[2] ^ cfg_q[g][CFG_INV_LSB+2],
				in_v[3] ^ cfg_q[g][CFG_INV_LSB+3]);
			// invert only a live form; no-operation stays false
			assign raw[g] = (op == OP_NONE || op > OP_ALL) ? 1'b0
				: comb ^ cfg_q[g][CFG_OUT_INV];
			work_bit_delay #(
				.DLY_W       (DLY_WIDTH)
			) u_delay (
				.i_core_clk  (i_core_clk),
				.i_rst_b     (i_rst_b),
				.i_eval      (eval_q),
				.i_unit_tick (unit_tick),
				.i_raw       (raw[g]),
				.i_on_dly    (on_q[g]),
				.i_off_dly   (off_q[g]),
				.o_out       (work[g])
			);
		end
	endgenerate

	// register port decode
	assign cfg_hit = i_addr[ADDR_W-1:3] == ADR_CFG0[ADDR_W-1:3];
	assign dly_hit = i_addr[ADDR_W-1:3] == ADR_DLY0[ADDR_W-1:3];
	assign idx     = i_addr[2:0];
	assign rd_mux  = cfg_hit ? cfg_q[idx]
		: dly_hit ? {2'b00, off_q[idx], 2'b00, on_q[idx]}
		: (i_addr == ADR_CTRL) ? {31'h0, minutes_q}
		: (i_addr == ADR_STATUS) ? {19'h0, pwr_q, ev_sync_q, work}
		: 32'h0;

	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			minutes_q <= 1'b0;
			rd_q      <= '0;
			for (int i = 0; i < NUM_BITS; i++)
			begin
				cfg_q[i] <= CFG_RESET;
				on_q[i]  <= DLY_RESET;
				off_q[i] <= DLY_RESET;
			end
		end
		else
		begin
			rd_q <= i_rd ? rd_mux : 32'h0;
			if (i_wr && i_addr == ADR_CTRL)
				minutes_q <= i_wr_data[CTRL_MINUTES];
			if (i_wr && cfg_hit)
				cfg_q[idx] <= i_wr_data;
			// out-of-range delays saturate at the top of the range
			if (i_wr && dly_hit)
			begin
				on_q[idx]  <= clamp(i_wr_data[DLY_ON_LSB +: 16]);
				off_q[idx] <= clamp(i_wr_data[DLY_OFF_LSB +: 16]);
			end
		end
	end

	assign o_work_bit = work;
	assign o_rd_data  = rd_q;

endmodule

`default_nettype wire

/* File: bench/work_bit_src_model.sv */
// model of the alarm, event and status sources of the combiner
`timescale 1ns/1ps
`default_nettype none
module work_bit_src_model
(
	input  wire logic [36:0] i_lvl,
	input  wire logic [2:0]  i_gate,
	output logic      [3:0]  o_ev,
	output logic      [2:0]  o_alm,
	output logic      [1:0]  o_sca,
	output logic      [1:0]  o_out,
	output logic      [2:0]  o_kind,
	output logic      [4:0]  o_err,
	output logic      [5:0]  o_st,
	output logic      [2:0]  o_bank,
	output logic             o_end
);
	// lvl bit n feeds the source read by code n; bit 36 is the 2nd count alarm
	assign o_ev   = i_lvl[6:3];
	assign o_alm  = i_lvl[9:7];
	assign o_sca  = {i_lvl[36], i_lvl[10]};
	assign o_out  = i_lvl[12:11];
	assign o_kind = i_gate;
	assign o_err  = i_lvl[17:13];
	assign o_st   = i_lvl[23:18];
	assign o_bank = i_lvl[26:24];
	assign o_end  = i_lvl[27];
endmodule
`default_nettype wire

/* File: bench/work_bit_logic_combiner_sva.sv */
// port assertions for the work bit combiner
`timescale 1ns/1ps
`default_nettype none
module work_bit_logic_combiner_chk
	import work_bit_pkg::*;
#(
	parameter int EVAL_CLKS = EVAL_CYCLES
)
(
	input wire logic        i_core_clk,
	input wire logic        i_rst_b,
	input wire logic [5:0]  i_addr,
	input wire logic [31:0] i_wr_data,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [3:0]  i_event_pin,
	input wire logic [7:0]  o_work_bit,
	input wire logic [31:0] o_rd_data
);
	logic       min_q;
	logic       cfg_q;
	logic [7:0] prev_q;
	int         gap_q;
	wire rd_stat = i_rd && i_addr == ADR_STATUS;
	wire rd_ctrl = i_rd && i_addr == ADR_CTRL;
	// gap counter: an early change would mean a stray evaluation
	always_ff @(posedge i_core_clk or negedge i_rst_b)
		if (!i_rst_b)
		begin
			min_q  <= 1'b0;
			cfg_q  <= 1'b0;
			prev_q <= 8'h00;
			gap_q  <= 0;
		end
		else
		begin
			if (i_wr && i_addr == ADR_CTRL)
				min_q <= i_wr_data[CTRL_MINUTES];
			cfg_q  <= cfg_q | (i_wr && i_addr[5:3] == 3'h1);
			prev_q <= o_work_bit;
			gap_q  <= (o_work_bit != prev_q) ? 1 : gap_q + 1;
		end
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_b);
	sequence s_read; i_rd ##1 !i_rd; endsequence
	property p_rd_idle; !$past(i_rd) |-> o_rd_data == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside answer");
	property p_rd_once; s_read |=> o_rd_data == 32'h0; endproperty
	a_rd_once: assert property (p_rd_once)
		else $error("read data held");
	property p_stat_bits;
		$past(rd_stat) |-> o_rd_data[7:0] == $past(o_work_bit);
	endproperty
	a_stat_bits: assert property (p_stat_bits)
		else $error("status bits wrong");
	property p_stat_ev;
		$past(rd_stat) |-> o_rd_data[11:8] == $past(i_event_pin, 3);
	endproperty
	a_stat_ev: assert property (p_stat_ev)
		else $error("status events wrong");
	property p_unit; $past(rd_ctrl) |-> o_rd_data == {31'h0, min_q}; endproperty
	a_unit: assert property (p_unit)
		else $error("unit readback wrong");
	property p_noop; !cfg_q |-> o_work_bit == 8'h00; endproperty
	a_noop: assert property (p_noop)
		else $error("work bit set while no-op");
	property p_gap; o_work_bit != prev_q |-> gap_q >= EVAL_CLKS; endproperty
	a_gap: assert property (p_gap)
		else $error("work bits changed between evaluations");
	property p_unmap;
		$past(i_rd && i_addr == 6'h3F) |-> o_rd_data == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap)
		else $error("unmapped read not zero");
endmodule
bind work_bit_logic_combiner work_bit_logic_combiner_chk
	#(.EVAL_CLKS(EVAL_CLKS)) u_chk (.i_core_clk, .i_rst_b, .i_addr,
	.i_wr_data, .i_wr, .i_rd, .i_event_pin, .o_work_bit, .o_rd_data);
`default_nettype wire

/* File: bench/tb_work_bit_logic_combiner.sv */
// self-checking bench for the work bit combiner
`timescale 1ns/1ps
`default_nettype none
module tb_work_bit_logic_combiner
	import work_bit_pkg::*;
;
	localparam int EC = 4;
	localparam int US = EVALS_PER_SEC * EC;
	logic        i_core_clk = 1'b0;
	logic        i_rst_b = 1'b0;
	logic [5:0]  i_addr = 6'h00;
	logic [31:0] i_wr_data = 32'h0;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic [36:0] lvl = '0;
	logic [2:0]  gate = 3'h2;
	logic [3:0]  fit = 4'hF;
	logic [3:0]  x;
	logic        oi;
	int          fails = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          n;
	wire logic [3:0]  ev;
	wire logic [2:0]  alm, kind, bank;
	wire logic [1:0]  sca, co;
	wire logic [4:0]  err;
	wire logic [5:0]  st;
	wire logic        pe;
	wire logic [7:0]  o_work_bit;
	wire logic [31:0] o_rd_data;
	always #20 i_core_clk = ~i_core_clk;
	work_bit_src_model u_src (.i_lvl(lvl), .i_gate(gate), .o_ev(ev),
		.o_alm(alm), .o_sca(sca), .o_out(co), .o_kind(kind), .o_err(err),
		.o_st(st), .o_bank(bank), .o_end(pe));
	work_bit_logic_combiner #(.EVAL_CLKS(EC)) u_dut (.i_core_clk, .i_rst_b,
		.i_addr, .i_wr_data, .i_wr, .i_rd, .i_event_pin(ev),
		.i_event_present(fit), .i_alarm(alm), .i_switch_count_alarm(sca),
		.i_ctrl_out1(co[0]), .i_ctrl_out1_linear(kind[2]),
		.i_ctrl_out2(co[1]), .i_ctrl_out2_present(kind[1]),
		.i_ctrl_out2_linear(kind[0]), .i_input_error(err[0]),
		.i_remote_setpoint_error(err[1]), .i_heater_burnout(err[2]),
		.i_heater_short(err[3]), .i_heater_overcurrent(err[4]),
		.i_auto_manual(st[0]), .i_run_stop(st[1]),
		.i_remote_local_setpoint(st[2]), .i_program_start(st[3]),
		.i_autotune_exec(st[4]), .i_setpoint_ramp(st[5]),
		.i_bank_no(bank), .i_program_end(pe), .o_work_bit, .o_rd_data);
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic w(input logic [5:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wr_data <= d;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask
	// source levels change only just after a rising edge
	task automatic drive(input logic [36:0] v);
		@(posedge i_core_clk);
		lvl <= v;
	endtask
	task automatic r(input logic [5:0] a, input logic [31:0] e);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		@(negedge i_core_clk);
		chk("rd_data", e, o_rd_data);
	endtask
	// three strobe periods, so at least two evaluations have landed
	task automatic settle;
		repeat (3 * EC) @(posedge i_core_clk);
		@(negedge i_core_clk);
	endtask
	task automatic meas(input logic v, input int lo, hi);
		int k;
		k = 0;
		while (o_work_bit[0] !== v && k <= hi)
		begin
			@(negedge i_core_clk);
			k++;
		end
		chk("delay", 1, k >= lo && k <= hi);
	endtask
	function automatic logic f(input int op, input logic [3:0] v);
		case (op)
			1: f = v[0] & v[1] | v[2] & v[3];
			2: f = (v[0] | v[2]) & (v[1] | v[3]);
			3: f = |v;
			default: f = &v;
		endcase
	endfunction
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge i_core_clk)
		if (++cyc == 20000)
		begin
			fails++;
			tally_and_finish;
		end
	initial
	begin
		repeat (5) @(posedge i_core_clk);
		i_rst_b <= 1'b1;
		w(ADR_CFG0, 32'h3000_0002);
		n = 0;
		repeat (4 * EC) @(negedge i_core_clk) n += (o_work_bit[0] === 1'b1);
		chk("power_on", EC, n);
		r(ADR_CTRL, 0);
		r(ADR_DLY0, 0);
		r(ADR_CFG0 + 6'h1, 0);
		r(6'h3F, 0);
		$display("test reset done");
		for (int op = 1; op <= 4; op++)
			for (int p = 0; p < 16; p++)
			begin
				// inversion on odd forms: selectors carry ~p, inputs see p
				x = p[3:0] ^ {4{op[0]}};
				oi = p[1] ^ op[1];
				w(ADR_CFG0, {oi, op[2:0], {4{op[0]}}, 5'h0, x[3], 5'h0, x[2],
					5'h0, x[1], 5'h0, x[0]});
				settle;
				chk("form", f(op, p[3:0]) ^ oi, o_work_bit[0]);
			end
		w(ADR_CFG0, 32'h8000_0041);
		settle;
		chk("no_op", 0, o_work_bit[0]);
		w(ADR_CFG0, 32'hF000_0001);
		settle;
		chk("no_op_code", 0, o_work_bit[0]);
		w(ADR_CFG0, 32'h3000_003F);
		settle;
		chk("bad_code", 0, o_work_bit[0]);
		$display("test forms done");
		for (int j = 3; j <= 28; j++)
		begin
			w(ADR_CFG0 + 6'h1, 32'h3000_0000 | (j == 28 ? 10 : j));
			lvl <= 37'h1 << (j == 28 ? 36 : j);
			settle;
			chk("source_on", 1, o_work_bit[1]);
			drive('0);
			settle;
			chk("source_off", 0, o_work_bit[1]);
		end
		for (int k = 0; k < 16; k++)
		begin
			drive(37'h1 << (11 + k[3]));
			gate <= k[2:0];
			w(ADR_CFG0 + 6'h1, 32'h3000_0000 | (11 + k[3]));
			settle;
			chk("gated", k[3] ? k[1] & !k[0] : !k[2], o_work_bit[1]);
		end
		drive('0);
		gate <= 3'h2;
		// event input 3 not fitted: its source must read false
		w(ADR_CFG0 + 6'h1, 32'h3000_0005);
		drive(37'h20);
		fit <= 4'hB;
		settle;
		chk("absent", 0, o_work_bit[1]);
		drive('0);
		fit <= 4'hF;
		$display("test sources done");
		w(ADR_CFG0, 32'h3000_0001);
		for (int b = 1; b < 8; b++)
			w(ADR_CFG0 + 6'(b), 32'h4000_0000 | (27 + b) * 32'h41041);
		repeat (4) settle;
		chk("chain", 8'hFF, o_work_bit);
		w(ADR_CFG0, 32'h3000_0023);
		settle;
		chk("ring", 8'hFF, o_work_bit);
		w(ADR_CFG0, 32'h3000_0000);
		n = 0;
		while (o_work_bit === 8'hFF && n++ < 3 * EC) @(negedge i_core_clk);
		chk("ripple", 8'hFE, o_work_bit);
		drive(37'h50);
		repeat (4) settle;
		r(ADR_STATUS, 32'h0000_0A00);
		$display("test feedback done");
		w(ADR_CFG0, 32'h3000_0007);
		w(ADR_DLY0, 32'h0002_0002);
		lvl <= 37'h80;
		meas(1, US - EC, 2 * US + 2 * EC);
		drive('0);
		meas(0, US - EC, 2 * US + 2 * EC);
		w(ADR_CTRL, 1);
		r(ADR_CTRL, 1);
		w(ADR_DLY0, 32'h0002_0000);
		lvl <= 37'h80;
		meas(1, 0, 2 * EC);
		drive('0);
		meas(0, SECS_PER_MIN * US - EC, 2 * SECS_PER_MIN * US + 2 * EC);
		w(ADR_DLY0, 32'h3FFF_3FFF);
		r(ADR_DLY0, {2'h0, DLY_MAX, 2'h0, DLY_MAX});
		$display("test delays done");
		tally_and_finish;
	end
endmodule
`default_nettype wire
